// ==== rtl/sbr_pkg.sv ====
// shared constants and the checksum function for the single-wire sensor readout link
package sbr_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int NS_PER_CYC = 1_000_000_000 / CLK_HZ;
  localparam int START_MIN_US = 800;   // 0.8 ms least start pulse
  localparam int START_TYP_US = 1000;  // 1 ms typical
  localparam int START_MAX_US = 20000; // 20 ms longest start pulse
  localparam int GAP_TYP_US = 30;      // line high before response
  localparam int RESP_TYP_US = 80;     // response low and high phases
  localparam int RESP_MIN_US = 75;
  localparam int RESP_MAX_US = 85;
  localparam int BITLOW_TYP_US = 50;
  localparam int BITLOW_MIN_US = 48;
  localparam int BITLOW_MAX_US = 55;
  localparam int ZERO_TYP_US = 26;     // zero_high_time
  localparam int ONE_TYP_US = 70;      // one_high_time
  localparam int THRESH_US = 50;       // host split between zero and one
  localparam int END_TYP_US = 50;      // closing low phase
  localparam int TIMEOUT_US = 300;     // host waits no longer for an edge
  localparam int CYC_PER_US = 1000 / NS_PER_CYC;
  // each count is the microsecond figure times CYC_PER_US, with no rounding
  localparam int START_MIN_CYC = START_MIN_US * CYC_PER_US;
  localparam int START_TYP_CYC = START_TYP_US * CYC_PER_US;
  localparam int START_MAX_CYC = START_MAX_US * CYC_PER_US;
  localparam int GAP_CYC = GAP_TYP_US * CYC_PER_US;
  localparam int RESP_CYC = RESP_TYP_US * CYC_PER_US;
  localparam int RESP_MIN_CYC = RESP_MIN_US * CYC_PER_US;
  localparam int RESP_MAX_CYC = RESP_MAX_US * CYC_PER_US;
  localparam int BITLOW_CYC = BITLOW_TYP_US * CYC_PER_US;
  localparam int BITLOW_MIN_CYC = BITLOW_MIN_US * CYC_PER_US;
  localparam int BITLOW_MAX_CYC = BITLOW_MAX_US * CYC_PER_US;
  localparam int ZERO_CYC = ZERO_TYP_US * CYC_PER_US;
  localparam int ONE_CYC = ONE_TYP_US * CYC_PER_US;
  localparam int THRESH_CYC = THRESH_US * CYC_PER_US;
  localparam int END_CYC = END_TYP_US * CYC_PER_US;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CYC_PER_US;
  localparam int CNT_W = 18;           // fits 20 ms at 10 MHz
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 40;
  localparam int WORD_W = 32;          // humidity and temperature words
  localparam int BIT_CNT_W = 6;
  localparam logic [31:0] MEAS_RST = 32'h0000_0000;

  // low eight bits of the sum of four data bytes
  function automatic logic [7:0] sbr_sum8(input logic [31:0] w);
    logic [9:0] s;
    s = {2'h0, w[31:24]} + {2'h0, w[23:16]} + {2'h0, w[15:8]} + {2'h0, w[7:0]};
    return s[7:0];
  endfunction
endpackage

// ==== rtl/sbr_link_if.sv ====
// open-drain data line shared by host and sensor
`timescale 1ns/1ps
interface sbr_link_if;
  logic host_oe;   // high while host pulls low
  logic dev_oe;    // high while sensor pulls low
  logic line_in;   // resolved level, pull-up when nobody drives
  assign line_in = ~(host_oe | dev_oe);
  modport host (output host_oe, input line_in);
  modport dev  (output dev_oe,  input line_in);
endinterface

// ==== rtl/sbr_sensor.sv ====
// sensor end: waits for start pulse, answers, sends the 40-bit frame
// Notes on behaviour
// RULE_01 - exactly forty bits, most significant first
// RULE_02 - host start low 0.8 to 20 ms
// RULE_03 - line high 20-200 us before response
// RULE_04 - response low 80 then high 80 us
// RULE_05 - each bit starts with 50 us low
// RULE_06 - zero bit high for 26 us
// RULE_07 - one bit high for 70 us
// RULE_08 - closing low 50 us then release
// RULE_09 - bytes: hum hi, hum lo, temp hi, lo, sum
// RULE_10 - humidity is ten times percent, unsigned
// RULE_11 - temperature sign-magnitude, tenths of degree
// RULE_12 - checksum is low byte of sum
// RULE_13 - host drops frame on bad checksum
// RULE_14 - start wakes, frame then measure, sleep
// RULE_15 - frame holds previous measurement; space reads
// RULE_16 - lines only pulled low or released
// RULE_17 - bad start sequence gets no response
// RULE_18 - host splits bits at 50 us, times out
`timescale 1ns/1ps
module sbr_sensor #(
  parameter int START_MIN = sbr_pkg::START_MIN_CYC,
  parameter int START_MAX = sbr_pkg::START_MAX_CYC,
  parameter int DEPTH     = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  sbr_link_if.dev          link,
  input  wire logic [15:0] meas_hum,
  input  wire logic [15:0] meas_temp,
  input  wire logic        meas_valid,
  output logic             meas_ready,
  output logic             meas_req,
  output logic             awake
);
  typedef enum {S_SLEEP, S_START, S_GAP, S_RLOW, S_RHIGH, S_BLOW, S_BHIGH,
                S_END} sbr_dstate_type;

  sbr_dstate_type            state_ff;
  logic [sbr_pkg::CNT_W-1:0] cnt_ff;
  logic [sbr_pkg::BIT_CNT_W-1:0] bit_ff;
  logic [39:0]               sh_ff;
  logic [31:0]               last_ff;
  logic                      oe_ff;
  logic                      req_ff;
  logic                      line_q_ff;
  logic                      f_valid;
  logic                      f_ready;
  logic [31:0]               f_data;

  // ----------------------------------------------------------------
  // measurement buffer: core drains one word only at frame load, in S_GAP
  // ----------------------------------------------------------------
  sbr_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .clock    (clock),
    .rst      (rst),
    .in_valid (meas_valid),
    .in_ready (meas_ready),
    .in_data  ({meas_hum, meas_temp}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       line_rise  = link.line_in & ~line_q_ff;
  wire logic       start_ok   = (cnt_ff >= sbr_pkg::CNT_W'(START_MIN)) &&
                                (cnt_ff <= sbr_pkg::CNT_W'(START_MAX)); // RULE_02
  wire logic       cur_bit    = sh_ff[39];
  wire logic [sbr_pkg::CNT_W-1:0] high_len = cur_bit ? sbr_pkg::CNT_W'(sbr_pkg::ONE_CYC)
                                           : sbr_pkg::CNT_W'(sbr_pkg::ZERO_CYC); // RULE_06 RULE_07
  wire logic       last_bit   = bit_ff == sbr_pkg::BIT_CNT_W'(sbr_pkg::FRAME_BITS - 1);
  // frame carries the word loaded at the previous wake
  wire logic [31:0] frame_w   = last_ff; // RULE_15
  assign f_ready = (state_ff == S_GAP) && (cnt_ff == sbr_pkg::CNT_W'(0));

  // ----------------------------------------------------------------
  // state machine; counter counts phase length
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff  <= S_SLEEP;
      cnt_ff    <= '0;
      bit_ff    <= '0;
      sh_ff     <= '0;
      last_ff   <= sbr_pkg::MEAS_RST;
      oe_ff     <= 1'b0;
      req_ff    <= 1'b0;
      line_q_ff <= 1'b1;
    end else begin
      line_q_ff <= link.line_in;
      req_ff    <= 1'b0;
      cnt_ff    <= cnt_ff + 1'b1;
      unique case (state_ff)
        S_SLEEP: begin
          cnt_ff <= '0;
          if (!link.line_in) state_ff <= S_START; // RULE_14
        end
        S_START: begin
          // saturate so an overlong pulse stays refused
          if (cnt_ff == '1) cnt_ff <= cnt_ff;
          if (line_rise) begin
            cnt_ff   <= '0;
            state_ff <= start_ok ? S_GAP : S_SLEEP; // RULE_17
          end
        end
        S_GAP: begin
          if (cnt_ff == sbr_pkg::CNT_W'(0)) begin
            if (f_valid) last_ff <= f_data;
            sh_ff <= {frame_w, sbr_pkg::sbr_sum8(frame_w)}; // RULE_09 RULE_10 RULE_11 RULE_12
          end
          if (!link.line_in) begin
            state_ff <= S_SLEEP; // RULE_17
          end else if (cnt_ff == sbr_pkg::CNT_W'(sbr_pkg::GAP_CYC - 1)) begin
            cnt_ff   <= '0;
            oe_ff    <= 1'b1; // RULE_03 RULE_04 RULE_16
            state_ff <= S_RLOW;
          end
        end
        S_RLOW: if (cnt_ff == sbr_pkg::CNT_W'(sbr_pkg::RESP_CYC - 1)) begin
          cnt_ff   <= '0;
          oe_ff    <= 1'b0; // RULE_04
          state_ff <= S_RHIGH;
        end
        S_RHIGH: if (cnt_ff == sbr_pkg::CNT_W'(sbr_pkg::RESP_CYC - 1)) begin
          cnt_ff   <= '0;
          bit_ff   <= '0;
          oe_ff    <= 1'b1; // RULE_05
          state_ff <= S_BLOW;
        end
        S_BLOW: if (cnt_ff == sbr_pkg::CNT_W'(sbr_pkg::BITLOW_CYC - 1)) begin
          cnt_ff   <= '0;
          oe_ff    <= 1'b0;
          state_ff <= S_BHIGH;
        end
        S_BHIGH: if (cnt_ff == high_len - 1'b1) begin
          cnt_ff   <= '0;
          oe_ff    <= 1'b1; // RULE_05 RULE_08
          sh_ff    <= {sh_ff[38:0], 1'b0}; // RULE_01
          bit_ff   <= bit_ff + 1'b1;
          state_ff <= last_bit ? S_END : S_BLOW;
        end
        S_END: if (cnt_ff == sbr_pkg::CNT_W'(sbr_pkg::END_CYC - 1)) begin
          oe_ff    <= 1'b0; // RULE_08
          req_ff   <= 1'b1; // RULE_14
          state_ff <= S_SLEEP;
        end
      endcase
    end
  end

  assign link.dev_oe = oe_ff;
  assign meas_req    = req_ff;
  always_ff @(posedge clock) begin
    if (rst) awake <= 1'b0;
    else awake <= (state_ff != S_SLEEP);
  end
endmodule

// ==== rtl/sbr_fifo.sv ====
// parameterised valid/ready fifo
`timescale 1ns/1ps
module sbr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             rdy_ff;

  wire logic        push    = in_valid & in_ready;
  wire logic        pop     = out_valid & out_ready;
  wire logic [AW:0] nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  // ready is registered so the sensor's meas_ready leaves straight from a flip-flop
  assign in_ready  = rdy_ff;
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem[rd_ff];

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else begin
      if (push) wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      if (pop) rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_cnt != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clock) begin
    if (push) mem[wr_ff] <= in_data;
  end
endmodule

// ==== rtl/sbr_host.sv ====
// host end: start pulse, response check, bit decode, checksum check
`timescale 1ns/1ps
module sbr_host #(
  parameter int START_LEN = sbr_pkg::START_TYP_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  sbr_link_if.host         link,
  input  wire logic        read_req,
  output logic             busy,
  output logic             done,
  output logic             frame_ok,
  output logic [15:0]      hum,
  output logic [15:0]      temp
);
  typedef enum {H_IDLE, H_START, H_WRESP, H_RLOW, H_RHIGH, H_BLOW, H_BHIGH,
                H_END} sbr_hstate_type;

  sbr_hstate_type            state_ff;
  logic [sbr_pkg::CNT_W-1:0] cnt_ff;
  logic [sbr_pkg::BIT_CNT_W-1:0] bit_ff;
  logic [39:0]               sh_ff;
  logic                      oe_ff;
  logic                      done_ff;
  logic                      ok_ff;
  logic [31:0]               word_ff;

  wire logic timeout = cnt_ff >= sbr_pkg::CNT_W'(sbr_pkg::TIMEOUT_CYC); // RULE_18
  wire logic bit_val = cnt_ff > sbr_pkg::CNT_W'(sbr_pkg::THRESH_CYC);   // RULE_18
  wire logic [39:0] nxt_sh = {sh_ff[38:0], bit_val};
  wire logic sum_ok = sbr_pkg::sbr_sum8(nxt_sh[39:8]) == nxt_sh[7:0];   // RULE_12

  // ----------------------------------------------------------------
  // transaction sequencer; any missing edge aborts with frame_ok low
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= H_IDLE;
      cnt_ff   <= '0;
      bit_ff   <= '0;
      sh_ff    <= '0;
      oe_ff    <= 1'b0;
      done_ff  <= 1'b0;
      ok_ff    <= 1'b0;
      word_ff  <= '0;
    end else begin
      done_ff <= 1'b0;
      cnt_ff  <= cnt_ff + 1'b1;
      unique case (state_ff)
        H_IDLE: begin
          cnt_ff <= '0;
          if (read_req) begin
            oe_ff    <= 1'b1; // RULE_02 RULE_16
            state_ff <= H_START;
          end
        end
        H_START: if (cnt_ff == sbr_pkg::CNT_W'(START_LEN - 1)) begin
          oe_ff    <= 1'b0; // RULE_02
          cnt_ff   <= '0;
          state_ff <= H_WRESP;
        end
        H_WRESP, H_RLOW, H_RHIGH, H_BLOW, H_BHIGH, H_END: begin
          if (timeout) begin
            done_ff  <= 1'b1;
            ok_ff    <= 1'b0;
            state_ff <= H_IDLE;
          end else if (state_ff == H_WRESP && !link.line_in) begin
            cnt_ff   <= '0;
            state_ff <= H_RLOW;
          end else if (state_ff == H_RLOW && link.line_in) begin
            cnt_ff   <= '0;
            state_ff <= H_RHIGH;
          end else if (state_ff == H_RHIGH && !link.line_in) begin
            cnt_ff   <= '0;
            bit_ff   <= '0;
            state_ff <= H_BLOW;
          end else if (state_ff == H_BLOW && link.line_in) begin
            cnt_ff   <= '0;
            state_ff <= H_BHIGH;
          end else if (state_ff == H_BHIGH && !link.line_in) begin
            cnt_ff   <= '0;
            sh_ff    <= nxt_sh; // RULE_01
            bit_ff   <= bit_ff + 1'b1;
            if (bit_ff == sbr_pkg::BIT_CNT_W'(sbr_pkg::FRAME_BITS - 1)) begin
              ok_ff    <= sum_ok;
              if (sum_ok) word_ff <= nxt_sh[39:8]; // RULE_13
              state_ff <= H_END;
            end else begin
              state_ff <= H_BLOW;
            end
          end else if (state_ff == H_END && link.line_in) begin
            done_ff  <= 1'b1;
            state_ff <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.host_oe = oe_ff;
  assign done     = done_ff;
  assign frame_ok = ok_ff;
  assign hum      = word_ff[31:16]; // RULE_09 RULE_10
  assign temp     = word_ff[15:0];  // RULE_11
  always_ff @(posedge clock) begin
    if (rst) busy <= 1'b0;
    else busy <= (state_ff != H_IDLE) || read_req;
  end
endmodule

// ==== verif/sbr_link_sva.sv ====
// checker for the shared single-wire line
`timescale 1ns/1ps
module sbr_link_sva #(
  parameter int SMIN = 10,
  parameter int SMAX = 100
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic line_in
);
  // ------------------------------
  // phase counters
  // ------------------------------
  logic [17:0] lo_ff;
  logic [17:0] hi_ff;
  logic [17:0] ho_ff;
  logic [5:0]  rise_ff;
  logic        dev_ff;
  // idle count stops at 4095 so a long idle never wraps into a legal length
  always_ff @(posedge clock) begin
    dev_ff  <= rst ? 1'b0 : dev_oe;
    lo_ff   <= dev_oe ? lo_ff + 18'h00001 : 18'h00000;
    ho_ff   <= host_oe ? ho_ff + 18'h00001 : 18'h00000;
    hi_ff   <= (rst || !line_in) ? 18'h00000 : hi_ff + {17'h00000, hi_ff < 18'h00FFF};
    rise_ff <= (rst || host_oe) ? 6'h00 : rise_ff + {5'h00, dev_oe && !dev_ff};
  end

  // ------------------------------
  // line timing
  // ------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  start_len_a: assert property (
    $fell(host_oe) |-> ho_ff inside {[SMIN:SMAX]}) else $error("start pulse length");
  gap_len_a: assert property (
    $rose(dev_oe) && rise_ff == 6'h00 |-> hi_ff inside {[200:2000]}) else $error("gap length");
  ack_high_a: assert property (
    $rose(dev_oe) && rise_ff == 6'h01 |-> hi_ff inside {[750:850]}) else $error("ack high");
  bit_high_a: assert property (
    $rose(dev_oe) && rise_ff > 6'h01 |-> hi_ff inside {[220:300], [680:750]})
    else $error("bit high length");
  bit_low_a: assert property (
    $fell(dev_oe) && rise_ff inside {[2:41]} |-> lo_ff inside {[480:550]})
    else $error("bit low length");
  end_low_a: assert property (
    $fell(dev_oe) && rise_ff == 6'h2A |-> lo_ff inside {[450:550]}) else $error("end low");
  frame_bits_a: assert property (
    hi_ff == 18'h003E8 && rise_ff != 6'h00 |-> rise_ff == 6'h2A) else $error("bit count");
  sleep_after_a: assert property (
    rise_ff == 6'h2A && !dev_oe && !host_oe |=> !dev_oe) else $error("drive after frame");
endmodule

// ==== verif/test_single_bus_sensor_readout.sv ====
// bench: host and sensor across one line, plus a sensor facing a rogue host
`timescale 1ns/1ps
module test_single_bus_sensor_readout;
  // ------------------------------
  // signals
  // ------------------------------
  logic        clock;
  logic        rst;
  logic        read_req;
  logic        meas_valid;
  logic [15:0] meas_hum;
  logic [15:0] meas_temp;
  logic        meas_ready;
  logic        meas_req;
  logic        awake;
  logic        done;
  logic        frame_ok;
  logic [15:0] hum;
  logic [15:0] temp;
  logic        busy;
  logic        meas_ready_b;
  logic        awake_b;
  logic        read_req_c;
  logic        done_c;
  logic        ok_c;
  logic [15:0] hum_c;
  logic [15:0] temp_c;
  logic [39:0] rx_ff;
  logic        dev_ff;
  int          hcnt;
  int          nrise;
  int          n_req;
  int          err_total;
  int          num_checks;
  logic [31:0] w [4];
  sbr_link_if link ();
  sbr_link_if link_b ();
  sbr_link_if link_c ();

  always #50 clock = ~clock;

  sbr_host #(.START_LEN(20)) sbr_host_inst (.clock(clock), .rst(rst), .link(link),
    .read_req(read_req), .busy(busy), .done(done), .frame_ok(frame_ok), .hum(hum), .temp(temp));
  sbr_sensor #(.START_MIN(10), .START_MAX(100)) sbr_sensor_inst (.clock(clock), .rst(rst),
    .link(link), .meas_hum(meas_hum), .meas_temp(meas_temp), .meas_valid(meas_valid),
    .meas_ready(meas_ready), .meas_req(meas_req), .awake(awake));
  // second sensor: the bench plays a host that breaks the start pulse limits
  sbr_sensor #(.START_MIN(10), .START_MAX(100)) sbr_sensor_inst2 (.clock(clock), .rst(rst),
    .link(link_b), .meas_hum(meas_hum), .meas_temp(meas_temp), .meas_valid(meas_valid),
    .meas_ready(meas_ready_b), .meas_req(), .awake(awake_b));
  // second host: the bench plays a sensor that corrupts or withholds its frame
  sbr_host sbr_host_inst2 (.clock(clock), .rst(rst), .link(link_c), .read_req(read_req_c),
    .busy(), .done(done_c), .frame_ok(ok_c), .hum(hum_c), .temp(temp_c));
  sbr_link_sva sbr_link_sva_inst (.clock(clock), .rst(rst),
    .host_oe(link.host_oe), .dev_oe(link.dev_oe), .line_in(link.line_in));

  // own decoder on the wire: bit value from its high phase, MSB first
  always @(posedge clock) begin
    dev_ff <= link.dev_oe;
    hcnt <= link.line_in ? hcnt + 1 : 0;
    if (meas_req === 1'b1) n_req <= n_req + 1;
    if (link.host_oe) nrise <= 0;
    else if (link.dev_oe && !dev_ff) begin
      nrise <= nrise + 1;
      if (nrise >= 2) rx_ff <= {rx_ff[38:0], hcnt > 500};
    end
  end

  // ------------------------------
  // tasks
  // ------------------------------
  function automatic logic [39:0] exp_frame(input logic [31:0] v);
    logic [7:0] s;
    s = v[31:24] + v[23:16] + v[15:8] + v[7:0];
    return {v, s};
  endfunction

  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({39'h0, got}, {39'h0, exp});
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // rogue start pulse of len cycles; exp says whether an answer must follow
  task automatic start_b(input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    link_b.host_oe <= 1'b1;
    repeat (len) @(posedge clock);
    link_b.host_oe <= 1'b0;
    for (int n = 0; n < 1200; n++) begin
      @(negedge clock);
      if (link_b.dev_oe === 1'b1) seen = 1'b1;
    end
    chk_bit(seen, exp);
  endtask

  // push words until the buffer refuses
  task automatic fill_fifo;
    int n;
    logic took;
    n = 0;
    took = 1'b1;
    while (took === 1'b1 && n < 8) begin
      @(posedge clock);
      meas_valid <= 1'b1;
      meas_hum <= w[n % 4][31:16];
      meas_temp <= w[n % 4][15:0];
      @(negedge clock);
      took = meas_ready;
      if (took === 1'b1) n++;
    end
    @(posedge clock);
    meas_valid <= 1'b0;
    chk_val(40'(n), 40'h4);
  endtask

  // bench plays the sensor on the third line, sending frame f with typical times
  task automatic send_frame(input logic [39:0] f);
    while (link_c.host_oe !== 1'b1) @(negedge clock);
    while (link_c.host_oe === 1'b1) @(negedge clock);
    repeat (300) @(posedge clock);
    link_c.dev_oe <= 1'b1;
    repeat (800) @(posedge clock);
    link_c.dev_oe <= 1'b0;
    repeat (800) @(posedge clock);
    for (int i = 39; i >= 0; i--) begin
      link_c.dev_oe <= 1'b1;
      repeat (500) @(posedge clock);
      link_c.dev_oe <= 1'b0;
      repeat (f[i] ? 700 : 260) @(posedge clock);
    end
    link_c.dev_oe <= 1'b1;
    repeat (500) @(posedge clock);
    link_c.dev_oe <= 1'b0;
  endtask

  // one readout by the second host; talk low leaves the line silent
  task automatic read_c(input logic [39:0] f, input logic talk, input logic exp_ok,
                        input logic [31:0] exp_w);
    int n;
    @(posedge clock);
    read_req_c <= 1'b1;
    @(posedge clock);
    read_req_c <= 1'b0;
    if (talk) send_frame(f);
    n = 0;
    while (done_c !== 1'b1 && n < 60000) begin
      @(negedge clock);
      n++;
    end
    chk_bit(done_c, 1'b1);
    chk_bit(ok_c, exp_ok);
    chk_val({8'h0, hum_c, temp_c}, {8'h0, exp_w});
  endtask

  // one readout; the closing low phase ends before done, then a 1000-cycle wait before busy is checked low
  task automatic do_read(input logic [31:0] v);
    int n;
    @(posedge clock);
    read_req <= 1'b1;
    @(posedge clock);
    read_req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge clock);
      n++;
    end
    chk_bit(done, 1'b1);
    chk_bit(busy, 1'b1);
    chk_bit(frame_ok, 1'b1);
    chk_val({24'h0, hum}, {24'h0, v[31:16]});
    chk_val({24'h0, temp}, {24'h0, v[15:0]});
    repeat (1000) @(negedge clock);
    chk_bit(busy, 1'b0);
    chk_val(rx_ff, exp_frame(v));
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    read_req = 1'b0;
    meas_valid = 1'b0;
    meas_hum = 16'h0000;
    meas_temp = 16'h0000;
    link_b.host_oe = 1'b0;
    link_c.dev_oe = 1'b0;
    read_req_c = 1'b0;
    rx_ff = 40'h0;
    hcnt = 0;
    nrise = 0;
    n_req = 0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(61));
    w[0] = $urandom;
    w[1] = 32'hFFFF_8065; // full humidity, negative temperature
    w[2] = 32'h0292_010D;
    w[3] = $urandom;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    fork
      begin
        start_b(5, 1'b0);
        start_b(150, 1'b0);
        chk_bit(meas_ready_b, 1'b0);
        start_b(20, 1'b1);
        chk_bit(meas_ready_b, 1'b1);
      end
      begin
        read_c(exp_frame(w[2]), 1'b1, 1'b1, w[2]);
        read_c(exp_frame(32'h0) ^ 40'h1, 1'b1, 1'b0, w[2]);
        read_c(40'h0, 1'b0, 1'b0, w[2]);
      end
      begin
        fill_fifo();
        chk_bit(meas_ready, 1'b0);
        do_read(32'h0000_0000);
        chk_bit(meas_ready, 1'b1);
        do_read(w[0]);
        do_read(w[1]);
      end
    join
    chk_val(40'(n_req), 40'h3);
    chk_bit(awake, 1'b0);
    chk_bit(awake_b, 1'b0);
    end_of_test();
  end

  // watchdog: three frames of at most about 50k cycles each, plus slack
  initial begin
    repeat (200000) @(posedge clock);
    err_total++;
    end_of_test();
  end
endmodule
